// ---- ufi_pkg.sv ----
// package of the usb interrupt flag block: register indices, field positions,
// reset values, timing constants and the grouped event carrier.
// assumes a 20 MHz reference clock and a 32-bit AXI4-Lite register bus.
package ufi_pkg;

  // ---------------------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ---------------------------------------------------------------------------
  localparam logic [5:0] BUS_IRQ_ENABLE_IDX   = 6'h06;
  localparam logic [5:0] TRN_IRQ_ENABLE_IDX   = 6'h07;
  localparam logic [5:0] EVENT_FLAGS_CLR_IDX  = 6'h0A;
  localparam logic [5:0] EVENT_FLAGS_SET_IDX  = 6'h0B;
  localparam logic [5:0] XFER_FLAGS_CLR_IDX   = 6'h0C;
  localparam logic [5:0] XFER_FLAGS_SET_IDX   = 6'h0D;
  localparam logic [5:0] PAD_TRIM_LOW_IDX     = 6'h3A;
  localparam logic [5:0] PAD_TRIM_HIGH_IDX    = 6'h3B;
  localparam int         ADDR_W               = 8;

  // ---------------------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------------------
  localparam int FRAME_START_BIT  = 7;  // enable and flag share bit 7
  localparam int BUS_EVENT_IE_BIT = 6;
  localparam int BUS_ERROR_IE_BIT = 5;
  localparam int STALL_IE_BIT     = 4;
  localparam int BUS_IDLE_BIT     = 6;
  localparam int BUS_WAKE_BIT     = 5;
  localparam int BUS_RESET_BIT    = 4;
  localparam int ISO_CRC_BIT      = 3;
  localparam int TX_STARVED_BIT   = 2;
  localparam int RX_REFUSED_BIT   = 1;
  localparam int HALT_BIT         = 0;
  localparam int TRANSFER_BIT     = 1;
  localparam int SETUP_BIT        = 0;

  // ---------------------------------------------------------------------------
  // writable masks and reset values
  // ---------------------------------------------------------------------------
  localparam logic [7:0] BUS_IRQ_ENABLE_MASK = 8'hF3;
  localparam logic [7:0] TRN_IRQ_ENABLE_MASK = 8'h03;
  localparam logic [7:0] XFER_FLAGS_MASK     = 8'h03;
  localparam logic [7:0] REG_RESET           = 8'h00;
  localparam logic [1:0] RESP_OKAY           = 2'h0;
  localparam logic [1:0] RESP_SLVERR         = 2'h2;

  // ---------------------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------------------
  localparam int CLK_HZ            = 20_000_000;
  localparam int SUSPEND_IDLE_MS   = 3;
  localparam int SUSPEND_IDLE_CYC  = SUSPEND_IDLE_MS * (CLK_HZ / 1000);
  localparam int IDLE_CNT_W        = 17;

  // ---------------------------------------------------------------------------
  // one-cycle bus event pulses from the usb engine
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic frame_start;    // sof packet received
    logic bus_reset;      // reset condition on the lines
    logic iso_crc_error;  // crc failure on isochronous out data
    logic tx_starved;     // in token, endpoint had nothing
    logic rx_refused;     // out token, endpoint not ready
    logic halt_sent;      // stall handshake answered
    logic setup_done;     // setup transaction completed
    logic transfer_done;  // in or out transaction completed
  } ufi_events_t;

  typedef enum logic [1:0] {
    UFI_ACTIVE    = 2'b01,
    UFI_SUSPENDED = 2'b10
  } ufi_link_state_t;

endpackage

// ---- ufi_flags.sv ----
// usb device interrupt enable, level and flag logic with pad trim registers.
// assumes events arrive as one-cycle pulses on ref_clk and that the done
// queue outside reports its pending level and pointer writes.
//
// Overview of operation
// - bus error enable gates crc, underflow, overflow
// - level zero blocks every usb interrupt request
// - stall enable gates stall flag interrupt
// - level field enables globally, each source enabled
// - transfer enable gates in/out completion interrupt
// - setup enable gates setup completion interrupt
// - flags at clear/set pair, same read value
// - ones set at set port, clear at clear
// - sof packet sets frame start flag
// - three ms idle sets bus idle flag
// - activity in suspend sets wake, asynchronous wake
// - bus reset condition sets reset flag
// - isochronous crc failure sets check error flag
// - empty in endpoint sets starved flag
// - busy out endpoint sets refused flag
// - stall handshake sets halt flag
// - pointer write or queue drain clears transfer flag
// - transfer flag high while queue enabled and entry pending
// - successful setup sets setup done flag
// - frame start enable gates sof interrupt
// - bus event enable gates idle, wake, reset
`timescale 1ns/1ns

module ufi_flags
  import ufi_pkg::*;
#(
  parameter int SUSPEND_CYCLES = ufi_pkg::SUSPEND_IDLE_CYC
) (
  input  wire  logic                        ref_clk,
  input  wire  logic                        rst_b,
  input  wire  logic [ufi_pkg::ADDR_W-1:0]  s_axi_awaddr,
  input  wire  logic                        s_axi_awvalid,
  output logic                              s_axi_awready,
  input  wire  logic [31:0]                 s_axi_wdata,
  input  wire  logic [3:0]                  s_axi_wstrb,
  input  wire  logic                        s_axi_wvalid,
  output logic                              s_axi_wready,
  output logic [1:0]                        s_axi_bresp,
  output logic                              s_axi_bvalid,
  input  wire  logic                        s_axi_bready,
  input  wire  logic [ufi_pkg::ADDR_W-1:0]  s_axi_araddr,
  input  wire  logic                        s_axi_arvalid,
  output logic                              s_axi_arready,
  output logic [31:0]                       s_axi_rdata,
  output logic [1:0]                        s_axi_rresp,
  output logic                              s_axi_rvalid,
  input  wire  logic                        s_axi_rready,
  input  wire  ufi_pkg::ufi_events_t        bus_events,
  input  wire  logic                        bus_idle,
  input  wire  logic                        done_queue_enable,
  input  wire  logic                        done_queue_pending,
  input  wire  logic                        done_queue_ptr_write,
  output logic [1:0]                        irq_priority_level,
  output logic                              cpu_wake,
  output logic                              link_suspended,
  output logic [15:0]                       pad_trim
);
  import ufi_pkg::*;

  // ---------------------------------------------------------------------------
  // axi4-lite slave state
  // ---------------------------------------------------------------------------
  logic              aw_full;
  logic [ADDR_W-1:0] aw_addr;
  logic              w_full;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;
  logic [1:0]        bresp;
  logic              bvalid;
  logic [31:0]       rdata;
  logic [1:0]        rresp;
  logic              rvalid;
  logic              next_aw_full;
  logic [ADDR_W-1:0] next_aw_addr;
  logic              next_w_full;
  logic [31:0]       next_w_data;
  logic [3:0]        next_w_strb;
  logic [1:0]        next_bresp;
  logic              next_bvalid;
  logic [31:0]       next_rdata;
  logic [1:0]        next_rresp;
  logic              next_rvalid;
  logic              wr_fire;
  logic [5:0]        wr_idx;
  logic [7:0]        wr_byte;
  logic              wr_hit;
  logic [5:0]        rd_idx;
  logic [7:0]        rd_byte;
  logic              rd_hit;

  // ---------------------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------------------
  logic [7:0]        bus_irq_enable;
  logic [7:0]        transaction_irq_enable;
  logic [7:0]        bus_event_flags;
  logic [7:0]        transaction_flags;
  logic [7:0]        pad_trim_low;
  logic [7:0]        pad_trim_high;
  logic [7:0]        next_bus_irq_enable;
  logic [7:0]        next_transaction_irq_enable;
  logic [7:0]        next_bus_event_flags;
  logic [7:0]        next_transaction_flags;
  logic [7:0]        next_pad_trim_low;
  logic [7:0]        next_pad_trim_high;
  logic [7:0]        ev_hw_set;
  logic [7:0]        ev_sw_set;
  logic [7:0]        ev_sw_clr;
  logic [7:0]        tr_set;
  logic [7:0]        tr_clr;

  // ---------------------------------------------------------------------------
  // link idle tracking
  // ---------------------------------------------------------------------------
  ufi_link_state_t        link_state;
  ufi_link_state_t        next_link_state;
  logic [IDLE_CNT_W-1:0]  idle_cnt;
  logic [IDLE_CNT_W-1:0]  next_idle_cnt;
  logic                   idle_hit;
  logic                   wake_hit;

  // ---------------------------------------------------------------------------
  // interrupt output
  // ---------------------------------------------------------------------------
  logic                   irq_any;
  logic [1:0]             next_irq_priority_level;

  // handshake outputs straight from the holding state
  assign s_axi_awready = !aw_full && !bvalid;
  assign s_axi_wready  = !w_full && !bvalid;
  assign s_axi_arready = !rvalid;
  assign s_axi_bvalid  = bvalid;
  assign s_axi_bresp   = bresp;
  assign s_axi_rvalid  = rvalid;
  assign s_axi_rdata   = rdata;
  assign s_axi_rresp   = rresp;

  // write decode once address and data are both held
  assign wr_fire = aw_full && w_full && !bvalid;
  assign wr_idx  = aw_addr[ADDR_W-1:2];
  assign wr_byte = w_strb[0] ? w_data[7:0] : 8'h00;
  assign rd_idx  = s_axi_araddr[ADDR_W-1:2];

  // address map hit check for both directions
  always_comb begin
    wr_hit = 1'b0;
    rd_hit = 1'b0;
    unique case (wr_idx)
      BUS_IRQ_ENABLE_IDX, TRN_IRQ_ENABLE_IDX, EVENT_FLAGS_CLR_IDX, EVENT_FLAGS_SET_IDX,
      XFER_FLAGS_CLR_IDX, XFER_FLAGS_SET_IDX, PAD_TRIM_LOW_IDX, PAD_TRIM_HIGH_IDX: begin
        wr_hit = 1'b1;
      end
      default: begin
        wr_hit = 1'b0;
      end
    endcase
    unique case (rd_idx)
      BUS_IRQ_ENABLE_IDX, TRN_IRQ_ENABLE_IDX, EVENT_FLAGS_CLR_IDX, EVENT_FLAGS_SET_IDX,
      XFER_FLAGS_CLR_IDX, XFER_FLAGS_SET_IDX, PAD_TRIM_LOW_IDX, PAD_TRIM_HIGH_IDX: begin
        rd_hit = 1'b1;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  // read mux; both addresses of a flag pair return the same byte
  always_comb begin
    rd_byte = 8'h00;
    unique case (rd_idx)
      BUS_IRQ_ENABLE_IDX:  rd_byte = bus_irq_enable;
      TRN_IRQ_ENABLE_IDX:  rd_byte = transaction_irq_enable;
      EVENT_FLAGS_CLR_IDX: rd_byte = bus_event_flags;
      EVENT_FLAGS_SET_IDX: rd_byte = bus_event_flags;
      XFER_FLAGS_CLR_IDX:  rd_byte = transaction_flags;
      XFER_FLAGS_SET_IDX:  rd_byte = transaction_flags;
      PAD_TRIM_LOW_IDX:    rd_byte = pad_trim_low;
      PAD_TRIM_HIGH_IDX:   rd_byte = pad_trim_high;
      default:             rd_byte = 8'h00;
    endcase
  end

  // channel holding, write response and read response next values
  always_comb begin
    next_aw_full = aw_full;
    next_aw_addr = aw_addr;
    next_w_full  = w_full;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    next_rvalid  = rvalid;
    next_rdata   = rdata;
    next_rresp   = rresp;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_full = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_full = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (wr_fire) begin
      next_aw_full = 1'b0;
      next_w_full  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rdata  = {24'h000000, rd_byte};
      next_rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  // axi slave registers
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      aw_full <= 1'b0;
      aw_addr <= '0;
      w_full  <= 1'b0;
      w_data  <= 32'h00000000;
      w_strb  <= 4'h0;
      bvalid  <= 1'b0;
      bresp   <= RESP_OKAY;
      rvalid  <= 1'b0;
      rdata   <= 32'h00000000;
      rresp   <= RESP_OKAY;
    end else begin
      aw_full <= next_aw_full;
      aw_addr <= next_aw_addr;
      w_full  <= next_w_full;
      w_data  <= next_w_data;
      w_strb  <= next_w_strb;
      bvalid  <= next_bvalid;
      bresp   <= next_bresp;
      rvalid  <= next_rvalid;
      rdata   <= next_rdata;
      rresp   <= next_rresp;
    end
  end

  // ---------------------------------------------------------------------------
  // flag set and clear terms
  // ---------------------------------------------------------------------------
  // hardware sets; each one overrides a same-cycle software clear
  always_comb begin
    ev_hw_set                 = 8'h00;
    ev_hw_set[FRAME_START_BIT] = bus_events.frame_start;
    ev_hw_set[BUS_IDLE_BIT]   = idle_hit;
    ev_hw_set[BUS_WAKE_BIT]   = wake_hit;
    ev_hw_set[BUS_RESET_BIT]  = bus_events.bus_reset;
    ev_hw_set[ISO_CRC_BIT]    = bus_events.iso_crc_error;
    ev_hw_set[TX_STARVED_BIT] = bus_events.tx_starved;
    ev_hw_set[RX_REFUSED_BIT] = bus_events.rx_refused;
    ev_hw_set[HALT_BIT]       = bus_events.halt_sent;
    ev_sw_set = (wr_fire && wr_idx == EVENT_FLAGS_SET_IDX) ? wr_byte : 8'h00;
    ev_sw_clr = (wr_fire && wr_idx == EVENT_FLAGS_CLR_IDX) ? wr_byte : 8'h00;
    tr_set = (wr_fire && wr_idx == XFER_FLAGS_SET_IDX) ? wr_byte : 8'h00;
    tr_clr = (wr_fire && wr_idx == XFER_FLAGS_CLR_IDX) ? wr_byte : 8'h00;
    tr_set[SETUP_BIT]    = tr_set[SETUP_BIT] | bus_events.setup_done;
    tr_set[TRANSFER_BIT] = tr_set[TRANSFER_BIT] | bus_events.transfer_done
                         | (done_queue_enable & done_queue_pending);
    tr_clr[TRANSFER_BIT] = tr_clr[TRANSFER_BIT] | done_queue_ptr_write
                         | (done_queue_enable & !done_queue_pending);
  end

  // register next values; zero bits written to a flag port change nothing
  always_comb begin
    next_bus_irq_enable         = bus_irq_enable;
    next_transaction_irq_enable = transaction_irq_enable;
    next_pad_trim_low           = pad_trim_low;
    next_pad_trim_high          = pad_trim_high;
    if (wr_fire && w_strb[0]) begin
      unique case (wr_idx)
        BUS_IRQ_ENABLE_IDX: next_bus_irq_enable = w_data[7:0] & BUS_IRQ_ENABLE_MASK;
        TRN_IRQ_ENABLE_IDX: next_transaction_irq_enable = w_data[7:0] & TRN_IRQ_ENABLE_MASK;
        PAD_TRIM_LOW_IDX:   next_pad_trim_low = w_data[7:0];
        PAD_TRIM_HIGH_IDX:  next_pad_trim_high = w_data[7:0];
        default:            next_pad_trim_low = pad_trim_low;
      endcase
    end
    next_bus_event_flags   = (bus_event_flags & ~ev_sw_clr) | ev_sw_set | ev_hw_set;
    next_transaction_flags = ((transaction_flags & ~tr_clr) | tr_set) & XFER_FLAGS_MASK;
  end

  // control and flag registers
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      bus_irq_enable         <= REG_RESET;
      transaction_irq_enable <= REG_RESET;
      bus_event_flags        <= REG_RESET;
      transaction_flags      <= REG_RESET;
      pad_trim_low           <= REG_RESET;
      pad_trim_high          <= REG_RESET;
    end else begin
      bus_irq_enable         <= next_bus_irq_enable;
      transaction_irq_enable <= next_transaction_irq_enable;
      bus_event_flags        <= next_bus_event_flags;
      transaction_flags      <= next_transaction_flags;
      pad_trim_low           <= next_pad_trim_low;
      pad_trim_high          <= next_pad_trim_high;
    end
  end

  assign pad_trim = {pad_trim_high, pad_trim_low};

  // ---------------------------------------------------------------------------
  // suspend detection and wake
  // ---------------------------------------------------------------------------
  // count idle cycles while active; leave suspend on any line activity
  always_comb begin
    next_link_state = link_state;
    next_idle_cnt   = '0;
    idle_hit        = 1'b0;
    wake_hit        = 1'b0;
    unique case (link_state)
      UFI_ACTIVE: begin
        if (bus_idle) begin
          if (idle_cnt == IDLE_CNT_W'(SUSPEND_CYCLES - 1)) begin
            idle_hit        = 1'b1;
            next_link_state = UFI_SUSPENDED;
          end else begin
            next_idle_cnt = idle_cnt + IDLE_CNT_W'(1);
          end
        end
      end
      UFI_SUSPENDED: begin
        if (!bus_idle) begin
          wake_hit        = 1'b1;
          next_link_state = UFI_ACTIVE;
        end
      end
      default: begin
        next_link_state = UFI_ACTIVE;
      end
    endcase
  end

  // link state registers
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      link_state <= UFI_ACTIVE;
      idle_cnt   <= '0;
    end else begin
      link_state <= next_link_state;
      idle_cnt   <= next_idle_cnt;
    end
  end

  // wake path needs no clock edge so a stopped clock still wakes the cpu
  assign cpu_wake       = (link_state == UFI_SUSPENDED) && !bus_idle;
  assign link_suspended = (link_state == UFI_SUSPENDED);

  // ---------------------------------------------------------------------------
  // interrupt request
  // ---------------------------------------------------------------------------
  // each source needs its enable (shared within the event and error groups), the level gates all of them
  always_comb begin
    irq_any = (bus_event_flags[FRAME_START_BIT] & bus_irq_enable[FRAME_START_BIT])
            | (|bus_event_flags[BUS_IDLE_BIT:BUS_RESET_BIT]
               & bus_irq_enable[BUS_EVENT_IE_BIT])
            | (|bus_event_flags[ISO_CRC_BIT:RX_REFUSED_BIT]
               & bus_irq_enable[BUS_ERROR_IE_BIT])
            | (bus_event_flags[HALT_BIT] & bus_irq_enable[STALL_IE_BIT])
            | (transaction_flags[TRANSFER_BIT] & transaction_irq_enable[TRANSFER_BIT])
            | (transaction_flags[SETUP_BIT] & transaction_irq_enable[SETUP_BIT]);
    next_irq_priority_level = irq_any ? bus_irq_enable[1:0] : 2'h0;
  end

  // registered request level
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_priority_level <= 2'h0;
    end else begin
      irq_priority_level <= next_irq_priority_level;
    end
  end

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  sequence seq_set_write;
    wr_fire && w_strb[0] && wr_idx == EVENT_FLAGS_SET_IDX;
  endsequence

  sequence seq_clr_write_quiet;
    wr_fire && w_strb[0] && wr_idx == EVENT_FLAGS_CLR_IDX && ev_hw_set == 8'h00;
  endsequence

  chk_level_zero_quiet: assert property (@(posedge ref_clk) disable iff (!rst_b)
    bus_irq_enable[1:0] == 2'h0 |=> irq_priority_level == 2'h0)
    else $error("request raised with level zero");

  chk_stall_request: assert property (@(posedge ref_clk) disable iff (!rst_b)
    bus_event_flags[HALT_BIT] && bus_irq_enable[STALL_IE_BIT] && bus_irq_enable[1:0] != 2'h0
    |=> irq_priority_level == $past(bus_irq_enable[1:0]))
    else $error("stall flag did not raise request");

  chk_error_request: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (|bus_event_flags[3:1]) && bus_irq_enable[BUS_ERROR_IE_BIT] && bus_irq_enable[1:0] != 2'h0
    |=> irq_priority_level != 2'h0)
    else $error("bus error flag did not raise request");

  chk_set_port: assert property (@(posedge ref_clk) disable iff (!rst_b)
    seq_set_write |=> (bus_event_flags & $past(wr_byte)) == $past(wr_byte))
    else $error("set port write did not set flags");

  chk_clear_port: assert property (@(posedge ref_clk) disable iff (!rst_b)
    seq_clr_write_quiet |=> (bus_event_flags & $past(wr_byte)) == 8'h00)
    else $error("clear port write did not clear flags");

  chk_frame_flag: assert property (@(posedge ref_clk) disable iff (!rst_b)
    bus_events.frame_start |=> bus_event_flags[FRAME_START_BIT])
    else $error("sof lost");

  chk_idle_flag: assert property (@(posedge ref_clk) disable iff (!rst_b)
    idle_hit |-> idle_cnt == IDLE_CNT_W'(SUSPEND_CYCLES - 1) ##1 bus_event_flags[BUS_IDLE_BIT])
    else $error("idle flag not set at count end");

  chk_wake_async: assert property (@(posedge ref_clk) disable iff (!rst_b)
    link_suspended && !bus_idle |-> cpu_wake ##1 bus_event_flags[BUS_WAKE_BIT])
    else $error("wake not signalled");

  chk_ptr_clears: assert property (@(posedge ref_clk) disable iff (!rst_b)
    done_queue_ptr_write && !bus_events.transfer_done && !done_queue_pending
    && !(wr_fire && wr_idx == XFER_FLAGS_SET_IDX) |=> !transaction_flags[TRANSFER_BIT])
    else $error("pointer write left transfer flag set");

  chk_setup_flag: assert property (@(posedge ref_clk) disable iff (!rst_b)
    bus_events.setup_done |=> transaction_flags[SETUP_BIT] ##1 1'b1)
    else $error("setup completion lost");

endmodule

// ---- ufi_host_model.sv ----
// far-side usb engine model: bench requests become event pulses and line state
// assumes requests change just after rising edges of ref_clk
`timescale 1ns/1ns
module ufi_host_model
  import ufi_pkg::*;
(
  input  wire logic                 ref_clk,
  input  wire ufi_pkg::ufi_events_t ev_req,
  input  wire logic                 idle_req,
  output ufi_pkg::ufi_events_t      bus_events,
  output logic                      bus_idle
);
  // lines start active, no packets seen
  initial begin
    bus_events = '0;
    bus_idle = 1'b0;
  end
  // launch one-cycle packets and idle level on the rising edge
  always @(posedge ref_clk) begin
    bus_events <= ev_req;
    bus_idle <= idle_req;
  end
endmodule

// ---- tb.sv ----
// testbench of the usb interrupt flag block over axi4-lite
// assumes ufi_pkg and ufi_host_model compiled first
`timescale 1ns/1ns
module tb;
  import ufi_pkg::*;
  logic ref_clk = 0, rst_b = 0, aw_v = 0, w_v = 0, b_r = 0, ar_v = 0, r_r = 0;
  logic qen = 0, qpend = 0, qwr = 0, idle_req = 0, aw_r, w_r, b_v, ar_r, r_v, wake, susp, idle;
  logic [7:0] aw_a = 0, ar_a = 0;
  logic [31:0] w_d = 0, r_d;
  logic [1:0] b_s, r_s, lvl;
  logic [15:0] trim;
  ufi_events_t ev_req = '0, evs;
  int err_count = 0, total_checks = 0;
  always #25 ref_clk = ~ref_clk;
  ufi_flags #(.SUSPEND_CYCLES(16)) i_ufi_flags (.ref_clk(ref_clk), .rst_b(rst_b),
    .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v), .s_axi_awready(aw_r), .s_axi_wdata(w_d),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(w_v), .s_axi_wready(w_r), .s_axi_bresp(b_s),
    .s_axi_bvalid(b_v), .s_axi_bready(b_r), .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v),
    .s_axi_arready(ar_r), .s_axi_rdata(r_d), .s_axi_rresp(r_s), .s_axi_rvalid(r_v),
    .s_axi_rready(r_r), .bus_events(evs), .bus_idle(idle), .done_queue_enable(qen),
    .done_queue_pending(qpend), .done_queue_ptr_write(qwr), .irq_priority_level(lvl),
    .cpu_wake(wake), .link_suspended(susp), .pad_trim(trim));
  ufi_host_model i_ufi_host_model (.ref_clk(ref_clk), .ev_req(ev_req), .idle_req(idle_req),
    .bus_events(evs), .bus_idle(idle));
  // ----------------------------------------
  // access and compare tasks
  // ----------------------------------------
  task chk(input string nm, input logic [33:0] e, input logic [33:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask
  // write: both channels offered, each released when taken, then response
  task wr(input logic [7:0] a, input logic [7:0] d);
    logic sa, sw, ta, tw, sb;
    logic [1:0] rs;
    {ta, tw} = 2'b00;
    aw_a <= a; w_d <= {24'h0, d}; aw_v <= 1; w_v <= 1; b_r <= 1;
    while (!(ta && tw)) begin
      @(negedge ref_clk);
      sa = aw_v && aw_r; sw = w_v && w_r;
      @(posedge ref_clk);
      if (sa) aw_v <= 0;
      if (sw) w_v <= 0;
      ta |= sa; tw |= sw;
    end
    do begin
      @(negedge ref_clk); sb = b_v; rs = b_s; @(posedge ref_clk);
    end while (!sb);
    b_r <= 0; @(posedge ref_clk);
    chk("bresp", 34'h0, {32'h0, rs});
  endtask
  // read and compare {rresp, rdata}
  task rd(input logic [7:0] a, input logic [33:0] e);
    logic sa, sr;
    logic [33:0] g;
    ar_a <= a; ar_v <= 1; r_r <= 1;
    do begin
      @(negedge ref_clk); sa = ar_r; @(posedge ref_clk);
    end while (!sa);
    ar_v <= 0;
    do begin
      @(negedge ref_clk); sr = r_v; g = {r_s, r_d}; @(posedge ref_clk);
    end while (!sr);
    r_r <= 0; @(posedge ref_clk);
    chk("read", e, g);
  endtask
  task ev(input logic [7:0] e);
    ev_req <= ufi_events_t'(e); @(posedge ref_clk); ev_req <= '0; repeat (2) @(posedge ref_clk);
  endtask
  task lv(input logic [1:0] e);
    repeat (2) @(negedge ref_clk);
    chk("level", {32'h0, e}, {32'h0, lvl});
    @(posedge ref_clk);
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // watchdog against a hung handshake
  initial begin
    repeat (3000) @(posedge ref_clk);
    err_count++;
    summarize();
  end
  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge ref_clk);
    rst_b <= 1;
    @(posedge ref_clk);
    rd(8'h18, 0); rd(8'hE8, 0);
    idle_req <= 1; repeat (20) @(posedge ref_clk);
    rd(8'h28, 8'h40); chk("susp", 1, susp);
    idle_req <= 0; @(posedge ref_clk); @(negedge ref_clk);
    chk("wake", 1, wake); @(posedge ref_clk);
    rd(8'h2C, 8'h60); chk("susp", 0, susp);
    wr(8'h28, 8'hFF); rd(8'h2C, 0);
    $display("test suspend done");
    for (int i = 0; i < 6; i++) begin
      ev(8'h80 >> i); rd(8'h28, (i == 0) ? 8'h80 : (8'h20 >> i)); wr(8'h28, 8'hFF);
    end
    wr(8'h18, 8'hF3); rd(8'h18, 8'hF3);
    wr(8'h2C, 8'h01); lv(3);
    wr(8'h18, 8'hF0); lv(0);
    wr(8'h18, 8'h21); lv(0); wr(8'h2C, 8'h04); lv(1);
    wr(8'h28, 8'hFF); lv(0);
    wr(8'h18, 8'h82); ev(8'h80); lv(2); wr(8'h28, 8'hFF);
    wr(8'h18, 8'h43); ev(8'h40); lv(3); wr(8'h28, 8'hFF);
    $display("test event flags done");
    wr(8'h18, 8'h01); wr(8'h1C, 8'h03); ev(8'h02); rd(8'h30, 8'h01); lv(1);
    wr(8'h30, 8'h01); lv(0); ev(8'h01); rd(8'h34, 8'h02); lv(1);
    qwr <= 1; @(posedge ref_clk); qwr <= 0; rd(8'h30, 0);
    qen <= 1; qpend <= 1; repeat (2) @(posedge ref_clk); rd(8'h30, 8'h02);
    qpend <= 0; repeat (2) @(posedge ref_clk); rd(8'h30, 0);
    $display("test transfer flags done");
    wr(8'hE8, 8'hA5); wr(8'hEC, 8'h3C); chk("trim", 34'h3CA5, {18'h0, trim});
    rd(8'h40, {RESP_SLVERR, 32'h0});
    $display("test trim done");
    summarize();
  end
endmodule
